// >>> verilog/icss_consts.svh
// Constants of the internal clock select block.
// Notes on behaviour
// - Any reset loads frequency select with 0111, giving 500 kHz.
// - High, mid and low frequency oscillators feed a postscaler multiplexer steered by frequency select.
// - Selectable rates run from 32 MHz down to 31 kHz, listed frequencies only.
// - Duplicate codes exist; same-source changes finish faster than cross-source changes.
// - 32 MHz needs the oscillator configuration select at 100 (internal source).
// - 32 MHz also needs system clock select at 00.
// - 32 MHz also needs frequency select 1110, the 8 MHz PLL input.
// - PLL runs when the software or the configuration PLL enable is set.
// - With the configuration PLL enable set, software cannot turn the PLL off.
// - System clock select 1x keeps the internal oscillator off the PLL.
// - After power-on or wake, execution starts at once on the internal clock.
// - Start-up timer counts 1024 external oscillator cycles before switching.
// - After timeout, wait for internal falling edge, then set startup status.
// - Crystal modes hold the clock low until an external falling edge, then switch.
// - Software reads startup status to learn whether the clock is external or internal.
`ifndef ICSS_CONSTS_SVH
`define ICSS_CONSTS_SVH

// Control word layout and reset value.
`define ICSS_IFS_RESET          4'h7
`define ICSS_SCS_RESET          2'h0
`define ICSS_SCS_FOLLOW_CONFIG  2'h0
`define ICSS_SPLL_RESET         1'b0

// Oscillator configuration select codes.
`define ICSS_FOSC_LP            3'h0
`define ICSS_FOSC_XT            3'h1
`define ICSS_FOSC_HS            3'h2
`define ICSS_FOSC_INTERNAL      3'h4

// Frequency select code that feeds the PLL.
`define ICSS_IFS_PLL_INPUT      4'hE

// Output frequencies in hertz.
`define ICSS_HZ_32M             26'd32000000
`define ICSS_HZ_16M             26'd16000000
`define ICSS_HZ_500K            26'd500000
`define ICSS_HZ_31K             26'd31000

// Start-up timer length in external oscillator cycles.
`define ICSS_OST_CYCLES         11'd1024

// Core clock rate and source change settle time.
`define ICSS_CLK_MHZ            10
`define ICSS_SRC_SETTLE_NS      2000

`endif

// >>> verilog/icss_pkg.sv
// Types shared by the internal clock select block.
package icss_pkg;

    // Software control word.
    typedef struct packed {
        logic       software_pll_enable;
        logic [3:0] internal_freq_select;
        logic [1:0] system_clock_select;
    } icss_ctrl_t;

    // Internal oscillator that feeds the postscaler.
    typedef enum logic [1:0] {
        ICSS_SRC_LF = 2'h0,
        ICSS_SRC_MF = 2'h1,
        ICSS_SRC_HF = 2'h2
    } icss_src_t;

    // Decoded frequency selection: source and postscaler power of two.
    typedef struct packed {
        icss_src_t  src;
        logic [3:0] div;
    } icss_sel_t;

    // Two-speed start-up states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ICSS_ST_INTERNAL = 3'h0,
        ICSS_ST_COUNT    = 3'h1,
        ICSS_ST_WAIT_INT = 3'h3,
        ICSS_ST_HOLD     = 3'h2,
        ICSS_ST_EXTERNAL = 3'h6
    } icss_state_t;

endpackage

// >>> verilog/icss_startup.sv
// Two-speed start-up sequencer with the oscillator start-up timer.
`timescale 1ns/10ps
`default_nettype none
`include "icss_consts.svh"

module icss_startup (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic restart_evt,
    input  wire logic ext_wanted,
    input  wire logic ext_crystal,
    input  wire logic int_fall,
    input  wire logic ext_fall,
    output logic      use_ext,
    output logic      hold_low,
    output logic      status
);

    icss_pkg::icss_state_t state_r;
    icss_pkg::icss_state_t state_nxt;
    logic [10:0]           ost_cnt_r;

    // Next state of the start-up sequence.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            icss_pkg::ICSS_ST_INTERNAL: begin
                if (ext_wanted) begin
                    state_nxt = icss_pkg::ICSS_ST_COUNT;
                end
            end
            icss_pkg::ICSS_ST_COUNT: begin
                if (ext_fall && ost_cnt_r == `ICSS_OST_CYCLES - 11'd1) begin
                    state_nxt = icss_pkg::ICSS_ST_WAIT_INT;
                end
            end
            icss_pkg::ICSS_ST_WAIT_INT: begin
                if (int_fall) begin
                    state_nxt = ext_crystal ? icss_pkg::ICSS_ST_HOLD : icss_pkg::ICSS_ST_EXTERNAL;
                end
            end
            icss_pkg::ICSS_ST_HOLD: begin
                if (ext_fall) begin
                    state_nxt = icss_pkg::ICSS_ST_EXTERNAL;
                end
            end
            icss_pkg::ICSS_ST_EXTERNAL: begin
                state_nxt = icss_pkg::ICSS_ST_EXTERNAL;
            end
            default: begin
                state_nxt = icss_pkg::ICSS_ST_INTERNAL;
            end
        endcase
        if (!ext_wanted) begin
            state_nxt = icss_pkg::ICSS_ST_INTERNAL;
        end else if (restart_evt) begin
            state_nxt = icss_pkg::ICSS_ST_COUNT;
        end
    end

    // State register; reset falls back to the internal clock.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= icss_pkg::ICSS_ST_INTERNAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Start-up timer counts external falling edges.
    always_ff @(posedge core_clk) begin
        if (rst || state_r != icss_pkg::ICSS_ST_COUNT || restart_evt) begin
            ost_cnt_r <= 11'd0;
        end else if (ext_fall) begin
            ost_cnt_r <= ost_cnt_r + 11'd1;
        end
    end

    // Status is set from the internal falling edge onward.
    assign status   = (state_r == icss_pkg::ICSS_ST_HOLD) || (state_r == icss_pkg::ICSS_ST_EXTERNAL);
    assign hold_low = (state_r == icss_pkg::ICSS_ST_HOLD);
    assign use_ext  = (state_r == icss_pkg::ICSS_ST_EXTERNAL);

endmodule
`default_nettype wire

// >>> verilog/icss_top.sv
// Internal oscillator frequency select, PLL gating and two-speed start-up.
`timescale 1ns/10ps
`default_nettype none
`include "icss_consts.svh"

module icss_top (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              ctrl_wr,
    input  wire icss_pkg::icss_ctrl_t ctrl_wdata,
    output icss_pkg::icss_ctrl_t   ctrl_rdata,
    input  wire logic [2:0]        config_fosc,
    input  wire logic              config_pll_enable,
    input  wire logic              restart_evt,
    input  wire logic              high_freq_internal_osc,
    input  wire logic              mid_freq_internal_osc,
    input  wire logic              low_freq_internal_osc,
    input  wire logic              ext_osc_in,
    input  wire logic              pll_clk_in,
    output logic                   sys_clk_out,
    output logic [25:0]            sys_freq_hz,
    output logic                   clk_source_ext,
    output logic                   pll_enable_out,
    output logic                   pll_active,
    output logic                   src_switching,
    output logic                   startup_timer_status
);

    // ************************************************************
    // Constants and helpers
    // ************************************************************

    // Settle time of a source change, rounded up to whole core cycles.
    localparam int SETTLE_INT = (`ICSS_SRC_SETTLE_NS * `ICSS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SETTLE_CYCLES = SETTLE_INT[7:0];

    // Frequency select code to oscillator and postscaler power.
    function automatic icss_pkg::icss_sel_t decode_sel(input logic [3:0] code);
        icss_pkg::icss_sel_t s;
        s.src = icss_pkg::ICSS_SRC_LF;
        s.div = 4'h0;
        case (code)
            4'h0, 4'h1: begin
                s.src = icss_pkg::ICSS_SRC_LF;
                s.div = 4'h0;
            end
            4'h2: begin
                s.src = icss_pkg::ICSS_SRC_MF;
                s.div = 4'h4;
            end
            4'h3: begin
                s.src = icss_pkg::ICSS_SRC_HF;
                s.div = 4'h9;
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
                s.src = icss_pkg::ICSS_SRC_MF;
                s.div = 4'h7 - code;
            end
            4'h8, 4'h9, 4'hA: begin
                s.src = icss_pkg::ICSS_SRC_MF;
                s.div = 4'hA - code;
            end
            4'hB, 4'hC, 4'hD, 4'hE, 4'hF: begin
                s.src = icss_pkg::ICSS_SRC_HF;
                s.div = 4'hF - code;
            end
            default: begin
                s.src = icss_pkg::ICSS_SRC_LF;
                s.div = 4'h0;
            end
        endcase
        return s;
    endfunction

    // Nominal output frequency of a decoded selection.
    function automatic logic [25:0] sel_hz(input icss_pkg::icss_sel_t s);
        logic [25:0] base;
        base = `ICSS_HZ_31K;
        case (s.src)
            icss_pkg::ICSS_SRC_HF: begin
                base = `ICSS_HZ_16M;
            end
            icss_pkg::ICSS_SRC_MF: begin
                base = `ICSS_HZ_500K;
            end
            default: begin
                base = `ICSS_HZ_31K;
            end
        endcase
        return base >> s.div;
    endfunction

    // Postscaled level: the source itself or one counter bit.
    function automatic logic post_level(input logic [8:0] cnt, input logic [3:0] div, input logic lvl);
        logic r;
        r = lvl;
        if (div != 4'h0) begin
            r = cnt[div - 4'h1];
        end
        return r;
    endfunction

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    logic [4:0] osc_meta_r;
    logic [4:0] osc_sync_r;
    logic [4:0] osc_prev_r;

    // Every oscillator level passes two flip-flops before use.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_meta_r <= 5'h00;
            osc_sync_r <= 5'h00;
        end else begin
            osc_meta_r <= {pll_clk_in, ext_osc_in, low_freq_internal_osc, mid_freq_internal_osc,
                           high_freq_internal_osc};
            osc_sync_r <= osc_meta_r;
        end
    end

    // Previous synchronised levels for edge detection.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_prev_r <= 5'h00;
        end else begin
            osc_prev_r <= osc_sync_r;
        end
    end

    logic ext_fall;
    logic pll_lvl;
    assign ext_fall = osc_prev_r[3] & ~osc_sync_r[3];
    assign pll_lvl  = osc_sync_r[4];

    // ************************************************************
    // Control word
    // ************************************************************

    icss_pkg::icss_ctrl_t ctrl_r;

    // Control word; reset restores the 500 kHz selection.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r.internal_freq_select <= `ICSS_IFS_RESET;
            ctrl_r.system_clock_select  <= `ICSS_SCS_RESET;
            ctrl_r.software_pll_enable  <= `ICSS_SPLL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= ctrl_wdata;
        end
    end

    assign ctrl_rdata = ctrl_r;

    // ************************************************************
    // PLL gating and source choice
    // ************************************************************

    logic pll_en;
    logic pll_use;
    logic fosc_internal;
    logic ext_wanted;
    logic ext_crystal;

    // The configuration enable overrides the software bit.
    assign pll_en = config_pll_enable | ctrl_r.software_pll_enable;

    assign fosc_internal = (config_fosc == `ICSS_FOSC_INTERNAL);

    // PLL path needs internal config, follow-config select and the 8 MHz code.
    assign pll_use = pll_en && fosc_internal
                     && ctrl_r.system_clock_select == `ICSS_SCS_FOLLOW_CONFIG
                     && ctrl_r.internal_freq_select == `ICSS_IFS_PLL_INPUT;

    // External source only while select bit 1 is clear (00 or 01) and the configuration is not internal.
    assign ext_wanted  = !ctrl_r.system_clock_select[1] && !fosc_internal;
    assign ext_crystal = (config_fosc == `ICSS_FOSC_LP) || (config_fosc == `ICSS_FOSC_XT)
                         || (config_fosc == `ICSS_FOSC_HS);

    // ************************************************************
    // Source switching and postscaler
    // ************************************************************

    icss_pkg::icss_sel_t sel_req;
    icss_pkg::icss_src_t cur_src_r;
    logic [3:0]          cur_div_r;
    logic [7:0]          settle_r;
    logic [8:0]          ps_cnt_r;
    logic                src_lvl;
    logic                src_prev;
    logic                int_clk_r;
    logic                int_clk_prev_r;
    logic                int_fall;

    assign sel_req = decode_sel(ctrl_r.internal_freq_select);

    // A new divider on the same source applies at once; a new source waits out the settle time.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_src_r <= icss_pkg::ICSS_SRC_MF;
            cur_div_r <= 4'h0;
            settle_r  <= 8'h00;
        end else if (sel_req.src == cur_src_r) begin
            cur_div_r <= sel_req.div;
            settle_r  <= 8'h00;
        end else if (settle_r == SETTLE_CYCLES - 8'h01) begin
            cur_src_r <= sel_req.src;
            cur_div_r <= sel_req.div;
            settle_r  <= 8'h00;
        end else begin
            settle_r <= settle_r + 8'h01;
        end
    end

    // Level of the oscillator feeding the postscaler.
    always_comb begin
        case (cur_src_r)
            icss_pkg::ICSS_SRC_HF: begin
                src_lvl  = osc_sync_r[0];
                src_prev = osc_prev_r[0];
            end
            icss_pkg::ICSS_SRC_MF: begin
                src_lvl  = osc_sync_r[1];
                src_prev = osc_prev_r[1];
            end
            default: begin
                src_lvl  = osc_sync_r[2];
                src_prev = osc_prev_r[2];
            end
        endcase
    end

    // Postscaler counts rising source edges; a source change restarts it.
    always_ff @(posedge core_clk) begin
        if (rst || sel_req.src != cur_src_r) begin
            ps_cnt_r <= 9'h000;
        end else if (src_lvl && !src_prev) begin
            ps_cnt_r <= ps_cnt_r + 9'h001;
        end
    end

    // Internal clock level, held low while a source change settles.
    always_ff @(posedge core_clk) begin
        if (rst || sel_req.src != cur_src_r) begin
            int_clk_r <= 1'b0;
        end else begin
            int_clk_r <= post_level(ps_cnt_r, cur_div_r, src_lvl);
        end
    end

    // Previous internal clock level for its falling edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_clk_prev_r <= 1'b0;
        end else begin
            int_clk_prev_r <= int_clk_r;
        end
    end

    assign int_fall = int_clk_prev_r & ~int_clk_r;

    // ************************************************************
    // Two-speed start-up
    // ************************************************************

    logic use_ext;
    logic hold_low;
    logic status;

    icss_startup u_startup (
        .core_clk    (core_clk),
        .rst         (rst),
        .restart_evt (restart_evt),
        .ext_wanted  (ext_wanted),
        .ext_crystal (ext_crystal),
        .int_fall    (int_fall),
        .ext_fall    (ext_fall),
        .use_ext     (use_ext),
        .hold_low    (hold_low),
        .status      (status)
    );

    // ************************************************************
    // System clock and status outputs
    // ************************************************************

    logic        sys_clk_r;
    logic [25:0] freq_r;
    logic        ext_r;
    logic        pll_act_r;
    logic        pll_en_r;
    logic        switching_r;
    logic        status_r;

    // System clock runs internally until the start-up sequence hands over.
    always_ff @(posedge core_clk) begin
        if (rst || hold_low) begin
            sys_clk_r <= 1'b0;
        end else if (use_ext) begin
            sys_clk_r <= osc_sync_r[3];
        end else if (pll_use) begin
            sys_clk_r <= pll_lvl;
        end else begin
            sys_clk_r <= int_clk_r;
        end
    end

    // Reported frequency; zero on the external clock, whose rate is unknown here.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            freq_r <= `ICSS_HZ_500K;
        end else if (use_ext) begin
            freq_r <= 26'd0;
        end else if (pll_use) begin
            freq_r <= `ICSS_HZ_32M;
        end else begin
            freq_r <= sel_hz(sel_req);
        end
    end

    // Registered status flags.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_r       <= 1'b0;
            pll_act_r   <= 1'b0;
            pll_en_r    <= 1'b0;
            switching_r <= 1'b0;
            status_r    <= 1'b0;
        end else begin
            ext_r       <= use_ext;
            pll_act_r   <= pll_use;
            pll_en_r    <= pll_en;
            switching_r <= (sel_req.src != cur_src_r);
            status_r    <= status;
        end
    end

    assign sys_clk_out          = sys_clk_r;
    assign sys_freq_hz          = freq_r;
    assign clk_source_ext       = ext_r;
    assign pll_enable_out       = pll_en_r;
    assign pll_active           = pll_act_r;
    assign src_switching        = switching_r;
    assign startup_timer_status = status_r;

endmodule
`default_nettype wire

// >>> tb/icss_props.sv
// Concurrent checks on the clock select block ports.
`timescale 1ns/10ps
`default_nettype none
`include "icss_consts.svh"

module icss_props (
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 ctrl_wr,
    input wire icss_pkg::icss_ctrl_t ctrl_wdata,
    input wire icss_pkg::icss_ctrl_t ctrl_rdata,
    input wire logic [2:0]           config_fosc,
    input wire logic                 config_pll_enable,
    input wire logic                 restart_evt,
    input wire logic                 ext_osc_in,
    input wire logic                 sys_clk_out,
    input wire logic [25:0]          sys_freq_hz,
    input wire logic                 clk_source_ext,
    input wire logic                 pll_enable_out,
    input wire logic                 pll_active,
    input wire logic                 src_switching,
    input wire logic                 startup_timer_status
);
    logic        ext_q_r;
    logic [11:0] fall_cnt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Raw external level, for fall detection.
    always_ff @(posedge core_clk) begin
        ext_q_r <= ext_osc_in;
    end

    // Counts raw external falls since reset or restart, saturating.
    always_ff @(posedge core_clk) begin
        if (rst || restart_evt) begin
            fall_cnt_r <= 12'h000;
        end else if (ext_q_r && !ext_osc_in && fall_cnt_r != 12'hFFF) begin
            fall_cnt_r <= fall_cnt_r + 12'h001;
        end
    end

    // Clock held low with status up, then the external source.
    sequence hold_s;
        startup_timer_status && !clk_source_ext && !sys_clk_out;
    endsequence
    sequence handover_s;
        hold_s ##[1:20] clk_source_ext;
    endsequence

    // ************************************************************
    // Port relations
    // ************************************************************
    reset_state_a: assert property ($fell(rst) |-> ctrl_rdata == 7'h1C && sys_freq_hz == `ICSS_HZ_500K)
        else $error("bad reset state");
    write_back_a: assert property (ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata))
        else $error("readback differs");
    pll_enable_a: assert property (!$past(rst) |-> pll_enable_out ==
        ($past(config_pll_enable) | $past(ctrl_rdata.software_pll_enable))) else $error("bad pll enable");
    pll_gate_a: assert property (pll_active |-> $past(config_fosc) == `ICSS_FOSC_INTERNAL
        && $past(ctrl_rdata.system_clock_select) == 2'h0) else $error("pll outside internal mode");
    pll_input_a: assert property (pll_active |-> $past(ctrl_rdata.internal_freq_select) == 4'hE
        && ($past(config_pll_enable) || $past(ctrl_rdata.software_pll_enable))) else $error("pll input wrong");
    pll_rate_a: assert property (pll_active |-> sys_freq_hz == `ICSS_HZ_32M)
        else $error("pll rate not 32 MHz");
    settle_bound_a: assert property ($rose(src_switching) |-> ##[1:25] !src_switching)
        else $error("source change too slow");
    count_min_a: assert property ($rose(startup_timer_status) |-> fall_cnt_r >= 12'd1023)
        else $error("status set before count end");
    hold_low_a: assert property ($rose(startup_timer_status) && config_fosc < 3'h3 |-> hold_s)
        else $error("clock not held low");
    handover_a: assert property ($rose(startup_timer_status) && config_fosc < 3'h3 |-> handover_s)
        else $error("no switch to external");
    ext_flag_a: assert property ($rose(clk_source_ext) |-> startup_timer_status)
        else $error("external without status");
endmodule

bind icss_top icss_props u_props (
    .core_clk(core_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .config_fosc(config_fosc), .config_pll_enable(config_pll_enable), .restart_evt(restart_evt),
    .ext_osc_in(ext_osc_in), .sys_clk_out(sys_clk_out), .sys_freq_hz(sys_freq_hz),
    .clk_source_ext(clk_source_ext), .pll_enable_out(pll_enable_out), .pll_active(pll_active),
    .src_switching(src_switching), .startup_timer_status(startup_timer_status)
);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the clock select block.
`timescale 1ns/10ps
`default_nettype none
`include "icss_consts.svh"

module tb_top;
    logic                 core_clk, rst, ctrl_wr, config_pll_enable, restart_evt;
    logic                 hf_osc, mf_osc, lf_osc, ext_osc, pll_osc;
    icss_pkg::icss_ctrl_t ctrl_wdata, ctrl_rdata;
    logic [2:0]           config_fosc;
    logic                 sys_clk_out, clk_source_ext, pll_enable_out, pll_active, src_switching;
    logic                 startup_timer_status;
    logic [25:0]          sys_freq_hz;
    int                   err_count, n_checks, ext_falls;

    icss_top dut (
        .core_clk(core_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
        .config_fosc(config_fosc), .config_pll_enable(config_pll_enable), .restart_evt(restart_evt),
        .high_freq_internal_osc(hf_osc), .mid_freq_internal_osc(mf_osc), .low_freq_internal_osc(lf_osc),
        .ext_osc_in(ext_osc), .pll_clk_in(pll_osc), .sys_clk_out(sys_clk_out), .sys_freq_hz(sys_freq_hz),
        .clk_source_ext(clk_source_ext), .pll_enable_out(pll_enable_out), .pll_active(pll_active),
        .src_switching(src_switching), .startup_timer_status(startup_timer_status)
    );

    // Core clock at 10 MHz.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Slow free-running oscillator stand-ins.
    always #400 hf_osc = ~hf_osc;
    always #500 mf_osc = ~mf_osc;
    always #700 lf_osc = ~lf_osc;
    always #230 ext_osc = ~ext_osc;
    always #300 pll_osc = ~pll_osc;
    always @(negedge ext_osc) ext_falls++;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic conclude();
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a level; running out ends the run.
    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            if (s === v) return;
            @(negedge core_clk);
        end
        err_count++;
        $display("MISMATCH at %0t: wait ran out", $time);
        conclude();
    endtask

    // One control write, one rising edge.
    task automatic wr(input logic [3:0] f, input logic [1:0] s, input logic p);
        @(negedge core_clk);
        ctrl_wdata = {p, f, s};
        ctrl_wr = 1'b1;
        @(negedge core_clk);
        ctrl_wr = 1'b0;
    endtask

    // Oscillator feeding each select code: 0 low, 1 mid, 2 high.
    function automatic logic [1:0] src_of(input logic [3:0] f);
        if (f < 4'h2) return 2'h0;
        if (f == 4'h3 || f > 4'hA) return 2'h2;
        return 2'h1;
    endfunction

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        check(ctrl_rdata, 7'h1C);
        check(sys_freq_hz, `ICSS_HZ_500K);
        check({startup_timer_status, clk_source_ext, pll_active}, 3'h0);
        wait_for(sys_clk_out, 1'b1, 30);
        wait_for(sys_clk_out, 1'b0, 30);
    endtask

    // Every select code, same-source and cross-source steps.
    task automatic t_freqs();
        logic [3:0]  codes [16] = '{4'hF, 4'hD, 4'hB, 4'hE, 4'h3, 4'h7, 4'h4, 4'hA,
                                    4'h8, 4'h2, 4'h0, 4'h1, 4'h5, 4'h6, 4'h9, 4'hC};
        logic [25:0] hz [16] = '{26'hF42400, 26'h3D0900, 26'h0F4240, 26'h7A1200, 26'h007A12, 26'h07A120,
                                 26'h00F424, 26'h07A120, 26'h01E848, 26'h007A12, 26'h007918, 26'h007918,
                                 26'h01E848, 26'h03D090, 26'h03D090, 26'h1E8480};
        logic [3:0]  prev;
        prev = 4'h7;
        foreach (codes[i]) begin
            wr(codes[i], 2'h0, 1'b0);
            repeat (2) @(negedge core_clk);
            check(src_switching, src_of(codes[i]) != src_of(prev));
            if (src_of(codes[i]) == src_of(prev)) check(sys_freq_hz, hz[i]);
            repeat (3) @(negedge core_clk);
            wait_for(src_switching, 1'b0, 40);
            check(sys_freq_hz, hz[i]);
            prev = codes[i];
        end
    endtask

    // PLL gating by code, select and both enables.
    task automatic t_pll();
        logic [3:0] f [6] = '{4'hE, 4'hE, 4'hF, 4'hE, 4'hE, 4'hE};
        logic [1:0] s [6] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h3};
        logic       p [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        logic       c [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic       a [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        foreach (f[i]) begin
            config_pll_enable = c[i];
            wr(f[i], s[i], p[i]);
            repeat (2) @(negedge core_clk);
            check(pll_enable_out, p[i] | c[i]);
            check(pll_active, a[i]);
            check(sys_freq_hz, a[i] ? `ICSS_HZ_32M : (f[i] == 4'hF ? `ICSS_HZ_16M : 26'h7A1200));
        end
    endtask

    // Two-speed start-up in crystal mode, then back to internal.
    task automatic t_startup();
        config_fosc = 3'h1;
        wr(4'hE, 2'h0, 1'b1);
        restart_evt = 1'b1;
        ext_falls = 0;
        @(negedge core_clk);
        restart_evt = 1'b0;
        check(pll_active, 1'b0);
        check(startup_timer_status, 1'b0);
        wait_for(startup_timer_status, 1'b1, 6000);
        check(ext_falls >= 1023 && ext_falls <= 1030, 1'b1);
        check(sys_clk_out, 1'b0);
        check(clk_source_ext, 1'b0);
        wait_for(clk_source_ext, 1'b1, 20);
        check(startup_timer_status, 1'b1);
        check(sys_freq_hz, 26'h0);
        wr(4'hE, 2'h2, 1'b0);
        repeat (4) @(negedge core_clk);
        check({clk_source_ext, startup_timer_status}, 2'h0);
        repeat (3) @(negedge core_clk);
        wait_for(src_switching, 1'b0, 40);
        check(sys_freq_hz, 26'h7A1200);
    endtask

    // Main sequence, with a second reset at the end.
    initial begin
        {rst, ctrl_wr, ctrl_wdata, config_pll_enable, restart_evt} = 11'h400;
        {hf_osc, mf_osc, lf_osc, ext_osc, pll_osc} = 5'h00;
        config_fosc = `ICSS_FOSC_INTERNAL;
        err_count = 0;
        n_checks = 0;
        t_reset();
        t_freqs();
        t_pll();
        t_startup();
        t_reset();
        conclude();
    end
endmodule
`default_nettype wire
